// *** rtl/uds_pkg.sv ***
// Constants shared by the UART data and status register block.
// Assumes a 32-bit register bus with word-aligned byte offsets.
package uds_pkg;
   // Register byte offsets
   localparam logic [11:0] UDS_OFF_CHAR_PORT = 12'h000;
   localparam logic [11:0] UDS_OFF_LINE_STATE = 12'h004;
   localparam logic [11:0] UDS_OFF_LINE_SETUP = 12'h008;
   localparam logic [11:0] UDS_OFF_BAUD_DIVIDER = 12'h00C;
   localparam logic [11:0] UDS_OFF_QUEUE_INSPECT = 12'h010;
   // Character field of the data register
   localparam int UDS_CHAR_LSB = 0;
   localparam int UDS_CHAR_W = 8;
   // Status field positions
   localparam int UDS_ST_RX_FILL_LSB = 26;
   localparam int UDS_ST_TX_FILL_LSB = 20;
   localparam int UDS_FILL_W = 6;
   localparam int UDS_ST_RX_FULL = 10;
   localparam int UDS_ST_TX_FULL = 9;
   localparam int UDS_ST_RX_HALF = 8;
   localparam int UDS_ST_TX_BELOW_HALF = 7;
   localparam int UDS_ST_FRAMING = 6;
   localparam int UDS_ST_PARITY = 5;
   localparam int UDS_ST_CHAR_LOST = 4;
   localparam int UDS_ST_NULL_FRAME = 3;
   localparam int UDS_ST_TX_EMPTY = 2;
   localparam int UDS_ST_SHIFT_IDLE = 1;
   localparam int UDS_ST_RX_READY = 0;
   // Queue depth and reset values
   localparam int UDS_FIFO_DEPTH = 8;
   localparam logic [31:0] UDS_RST_CHAR_PORT = 32'h0000_0000;
   localparam logic [31:0] UDS_RST_LINE_SETUP = 32'h0000_0000;
   localparam logic [31:0] UDS_RST_BAUD_DIVIDER = 32'h0000_0000;
   localparam logic [31:0] UDS_RST_QUEUE_INSPECT = 32'h0000_0000;
   localparam logic UDS_RST_SHIFT_IDLE = 1'b1;
endpackage

// *** rtl/uds_fifo.sv ***
// Byte queue used for both the transmit and receive directions.
// Ignores a push when full and a pop when empty.
`timescale 1ns/1ns
`default_nettype none
module uds_fifo
   import uds_pkg::*;
#(
   parameter int WIDTH = UDS_CHAR_W,
   parameter int DEPTH = UDS_FIFO_DEPTH,
   parameter int CNT_W = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Fill side
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   // Drain side
   input wire logic pop,
   output logic [WIDTH-1:0] head_data,
   // Level
   output logic [CNT_W-1:0] count,
   output logic full,
   output logic empty
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] rd_ptr;
      logic [PTR_W-1:0] wr_ptr;
      logic [CNT_W-1:0] cnt;
   } uds_fifo_state_t;

   uds_fifo_state_t st_ff;
   uds_fifo_state_t nxt_st;
   logic do_push;
   logic do_pop;

   // Guard the pointers so a stray strobe cannot corrupt the queue
   assign do_push = push && (st_ff.cnt != CNT_W'(DEPTH));
   assign do_pop = pop && (st_ff.cnt != '0);

   // Pointer, count and storage update
   always_comb begin
      nxt_st = st_ff;
      if (do_push) begin
         nxt_st.mem[st_ff.wr_ptr] = push_data;
         nxt_st.wr_ptr = (st_ff.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         nxt_st.rd_ptr = (st_ff.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign head_data = st_ff.mem[st_ff.rd_ptr];
   assign count = st_ff.cnt;
   assign full = (st_ff.cnt == CNT_W'(DEPTH));
   assign empty = (st_ff.cnt == '0);
endmodule
`default_nettype wire

// *** rtl/uds_regs.sv ***
// UART data and status register block with its two byte queues.
// Assumes an APB master on the register side and a framing engine on
// the line side that strobes received characters and asks for the next
// character to send.
`timescale 1ns/1ns
`default_nettype none

module uds_regs
   import uds_pkg::*;
#(
   parameter int DEPTH = UDS_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive side of the framing engine
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   input wire logic rx_frame_err,
   input wire logic rx_parity_err,
   input wire logic rx_break,
   input wire logic rx_shift_overrun,
   // Transmit side of the framing engine
   input wire logic tx_take,
   input wire logic tx_shift_busy,
   output logic [7:0] tx_char,
   output logic tx_char_valid,
   output logic tx_pending,
   // Configuration words for the engine and scaler
   output logic [31:0] line_setup,
   output logic [31:0] baud_divider,
   output logic [31:0] queue_inspect
);
   localparam int CNT_W = $clog2(DEPTH + 1);

   // Queue depth must fit the six-bit fill fields and split into halves
   if (DEPTH < 2 || DEPTH > 63 || (DEPTH % 2) != 0) begin : g_bad_depth
      $error("uds_regs: DEPTH must be even and within 2..63");
   end

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic rd_had_char;
      logic framing_error;
      logic parity_error;
      logic char_lost_flag;
      logic null_frame_seen;
      logic [31:0] line_setup;
      logic [31:0] baud_divider;
      logic [31:0] queue_inspect;
      logic [7:0] tx_char;
      logic tx_char_valid;
      logic tx_pending;
      logic tx_shift_idle;
   } uds_regs_state_t;

   uds_regs_state_t st_ff;
   uds_regs_state_t nxt_st;

   // Queue wiring
   logic rx_push;
   logic rx_pop;
   logic [7:0] rx_head;
   logic [CNT_W-1:0] rx_cnt;
   logic rx_full;
   logic rx_empty;
   logic tx_push;
   logic tx_pop;
   logic [7:0] tx_head;
   logic [CNT_W-1:0] tx_cnt;
   logic tx_full;
   logic tx_empty;

   // Bus phase decode
   logic setup_ph;
   logic access_done;
   logic sel_char;
   logic sel_state;
   logic sel_setup;
   logic sel_baud;
   logic sel_inspect;
   logic mapped;
   logic rx_bad;
   logic [31:0] status_word;
   logic [UDS_FILL_W-1:0] rx_fill_level;
   logic [UDS_FILL_W-1:0] tx_fill_level;

   assign setup_ph = psel && !penable;
   assign access_done = psel && penable && st_ff.ready;
   // Word decode; the low address bits must be zero for a hit
   assign sel_char = (paddr == UDS_OFF_CHAR_PORT);
   assign sel_state = (paddr == UDS_OFF_LINE_STATE);
   assign sel_setup = (paddr == UDS_OFF_LINE_SETUP);
   assign sel_baud = (paddr == UDS_OFF_BAUD_DIVIDER);
   assign sel_inspect = (paddr == UDS_OFF_QUEUE_INSPECT);
   assign mapped = sel_char || sel_state || sel_setup || sel_baud || sel_inspect;

   // A framing, parity or break report keeps the frame out of the receive queue; an overrun does not
   assign rx_bad = rx_frame_err || rx_parity_err || rx_break;
   assign rx_push = rx_char_valid && !rx_bad && !rx_full;
   // Pop only a byte that was really captured in the setup phase
   assign rx_pop = access_done && !pwrite && sel_char && st_ff.rd_had_char;
   // A write into a full queue is dropped rather than overwriting
   assign tx_push = access_done && pwrite && sel_char && !tx_full;
   assign tx_pop = tx_take && !tx_empty;

   // Fill counts zero-extended into the six-bit fields
   assign rx_fill_level = UDS_FILL_W'(rx_cnt);
   assign tx_fill_level = UDS_FILL_W'(tx_cnt);

   // Status word; everything not listed reads zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[UDS_ST_RX_FILL_LSB +: UDS_FILL_W] = rx_fill_level;
      status_word[UDS_ST_TX_FILL_LSB +: UDS_FILL_W] = tx_fill_level;
      status_word[UDS_ST_RX_FULL] = rx_full;
      status_word[UDS_ST_TX_FULL] = tx_full;
      status_word[UDS_ST_RX_HALF] = (rx_cnt >= CNT_W'(DEPTH / 2));
      status_word[UDS_ST_TX_BELOW_HALF] = (tx_cnt < CNT_W'(DEPTH / 2));
      status_word[UDS_ST_FRAMING] = st_ff.framing_error;
      status_word[UDS_ST_PARITY] = st_ff.parity_error;
      status_word[UDS_ST_CHAR_LOST] = st_ff.char_lost_flag;
      status_word[UDS_ST_NULL_FRAME] = st_ff.null_frame_seen;
      status_word[UDS_ST_TX_EMPTY] = tx_empty;
      status_word[UDS_ST_SHIFT_IDLE] = st_ff.tx_shift_idle;
      status_word[UDS_ST_RX_READY] = !rx_empty;
   end

   // Next state of the register file and the engine handshake
   always_comb begin
      nxt_st = st_ff;
      // Read data is captured in setup so prdata comes from a flop
      nxt_st.ready = setup_ph;
      nxt_st.slverr = setup_ph && !mapped;
      nxt_st.rd_had_char = 1'b0;
      if (setup_ph) begin
         nxt_st.rdata = 32'h0000_0000;
         if (!pwrite) begin
            if (sel_char) begin
               // Upper bits stay zero
               nxt_st.rdata[UDS_CHAR_LSB +: UDS_CHAR_W] = rx_empty ? 8'h00 : rx_head;
               nxt_st.rd_had_char = !rx_empty;
            end else if (sel_state) begin
               nxt_st.rdata = status_word;
            end else if (sel_setup) begin
               nxt_st.rdata = st_ff.line_setup;
            end else if (sel_baud) begin
               nxt_st.rdata = st_ff.baud_divider;
            end else if (sel_inspect) begin
               nxt_st.rdata = st_ff.queue_inspect;
            end
         end
      end
      // Software clears a flag by writing zero to it
      if (access_done && pwrite && sel_state) begin
         nxt_st.framing_error = st_ff.framing_error & pwdata[UDS_ST_FRAMING];
         nxt_st.parity_error = st_ff.parity_error & pwdata[UDS_ST_PARITY];
         nxt_st.char_lost_flag = st_ff.char_lost_flag & pwdata[UDS_ST_CHAR_LOST];
         nxt_st.null_frame_seen = st_ff.null_frame_seen & pwdata[UDS_ST_NULL_FRAME];
      end
      // New errors are OR'ed in afterwards so a set beats a clear
      if (rx_char_valid) begin
         nxt_st.framing_error = nxt_st.framing_error | rx_frame_err;
         nxt_st.parity_error = nxt_st.parity_error | rx_parity_err;
         nxt_st.null_frame_seen = nxt_st.null_frame_seen | rx_break;
         if (!rx_bad && rx_full) begin
            nxt_st.char_lost_flag = 1'b1;
         end
      end
      if (rx_shift_overrun) begin
         nxt_st.char_lost_flag = 1'b1;
      end
      // Plain storage words for the engine and scaler
      if (access_done && pwrite) begin
         if (sel_setup) begin
            nxt_st.line_setup = pwdata;
         end
         if (sel_baud) begin
            nxt_st.baud_divider = pwdata;
         end
         if (sel_inspect) begin
            nxt_st.queue_inspect = pwdata;
         end
      end
      // Hand the oldest queued character to the engine one cycle after asking
      nxt_st.tx_char_valid = tx_pop;
      if (tx_pop) begin
         nxt_st.tx_char = tx_head;
      end
      // Pending follows the queue after this cycle's push and pop
      nxt_st.tx_pending = !(tx_empty && !tx_push) && !(tx_cnt == CNT_W'(1) && tx_pop && !tx_push);
      nxt_st.tx_shift_idle = !tx_shift_busy;
   end

   // State register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.line_setup <= UDS_RST_LINE_SETUP;
         st_ff.baud_divider <= UDS_RST_BAUD_DIVIDER;
         st_ff.queue_inspect <= UDS_RST_QUEUE_INSPECT;
         st_ff.tx_shift_idle <= UDS_RST_SHIFT_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Receive queue, eight entries by default
   uds_fifo #(
      .WIDTH(UDS_CHAR_W),
      .DEPTH(DEPTH),
      .CNT_W(CNT_W)
   ) u_rx_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .push(rx_push),
      .push_data(rx_char),
      .pop(rx_pop),
      .head_data(rx_head),
      .count(rx_cnt),
      .full(rx_full),
      .empty(rx_empty)
   );

   // Transmit queue, eight entries by default
   uds_fifo #(
      .WIDTH(UDS_CHAR_W),
      .DEPTH(DEPTH),
      .CNT_W(CNT_W)
   ) u_tx_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .push(tx_push),
      .push_data(pwdata[UDS_CHAR_LSB +: UDS_CHAR_W]),
      .pop(tx_pop),
      .head_data(tx_head),
      .count(tx_cnt),
      .full(tx_full),
      .empty(tx_empty)
   );

   // Outputs straight from the state register
   assign prdata = st_ff.rdata;
   assign pready = st_ff.ready;
   assign pslverr = st_ff.slverr;
   assign tx_char = st_ff.tx_char;
   assign tx_char_valid = st_ff.tx_char_valid;
   assign tx_pending = st_ff.tx_pending;
   assign line_setup = st_ff.line_setup;
   assign baud_divider = st_ff.baud_divider;
   assign queue_inspect = st_ff.queue_inspect;

   // Checks on the read and write paths, the queue levels and the flags
   property p_unmapped_err;
      @(posedge clock) disable iff (!rst_b)
      (setup_ph && !mapped) |=> (pready && pslverr && prdata == 32'h0000_0000);
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not flagged");

   property p_char_read;
      @(posedge clock) disable iff (!rst_b)
      (setup_ph && !pwrite && sel_char && !rx_empty && penable == 1'b0)
         |=> (prdata == {24'h000000, $past(rx_head)}) ##1 (rx_cnt == $past(rx_cnt) - CNT_W'(1) + CNT_W'($past(rx_push)));
   endproperty
   a_char_read: assert property (p_char_read) else $error("data read did not return and pop head");

   property p_char_write;
      @(posedge clock) disable iff (!rst_b)
      (tx_push && !tx_pop) |=> (tx_cnt == $past(tx_cnt) + CNT_W'(1));
   endproperty
   a_char_write: assert property (p_char_write) else $error("data write did not enter queue");

   property p_rx_level;
      @(posedge clock) disable iff (!rst_b)
      (setup_ph && !pwrite && sel_state) |=> (prdata[31:26] == UDS_FILL_W'($past(rx_cnt))
         && prdata[25:20] == UDS_FILL_W'($past(tx_cnt)));
   endproperty
   a_rx_level: assert property (p_rx_level) else $error("fill levels misreported");

   property p_depth;
      @(posedge clock) disable iff (!rst_b)
      (rx_cnt <= CNT_W'(DEPTH)) && (tx_cnt <= CNT_W'(DEPTH));
   endproperty
   a_depth: assert property (p_depth) else $error("queue exceeds depth");

   property p_full_bits;
      @(posedge clock) disable iff (!rst_b)
      (setup_ph && !pwrite && sel_state) |=> (prdata[10] == ($past(rx_cnt) == CNT_W'(DEPTH))
         && prdata[9] == ($past(tx_cnt) == CNT_W'(DEPTH)) && prdata[2] == ($past(tx_cnt) == '0)
         && prdata[0] == ($past(rx_cnt) != '0));
   endproperty
   a_full_bits: assert property (p_full_bits) else $error("full or empty bits wrong");

   property p_half_bits;
      @(posedge clock) disable iff (!rst_b)
      (setup_ph && !pwrite && sel_state) |=> (prdata[8] == ($past(rx_cnt) >= CNT_W'(DEPTH / 2))
         && prdata[7] == ($past(tx_cnt) < CNT_W'(DEPTH / 2)) && prdata[19:11] == 9'h000);
   endproperty
   a_half_bits: assert property (p_half_bits) else $error("half bits wrong");

   property p_err_set;
      @(posedge clock) disable iff (!rst_b)
      (rx_char_valid && rx_frame_err) |=> st_ff.framing_error [*2];
   endproperty
   a_err_set: assert property (p_err_set) else $error("framing flag not held");

   property p_err_no_push;
      @(posedge clock) disable iff (!rst_b)
      (rx_char_valid && (rx_parity_err || rx_break)) |-> !rx_push ##1 (st_ff.parity_error || st_ff.null_frame_seen);
   endproperty
   a_err_no_push: assert property (p_err_no_push) else $error("bad frame queued");

   property p_lost;
      @(posedge clock) disable iff (!rst_b)
      (rx_char_valid && !rx_bad && rx_full) |=> st_ff.char_lost_flag;
   endproperty
   a_lost: assert property (p_lost) else $error("lost character not flagged");

   property p_idle;
      @(posedge clock) disable iff (!rst_b)
      tx_shift_busy |=> !st_ff.tx_shift_idle;
   endproperty
   a_idle: assert property (p_idle) else $error("shift idle wrong");
endmodule
`default_nettype wire

// *** bench/uds_engine_model.sv ***
// Behavioural framing engine facing the line side of the register block.
// Assumes the bench calls its tasks from one process, one at a time.
`timescale 1ns/1ns
`default_nettype none
module uds_engine_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Receive strobes towards the block
   output logic rx_char_valid,
   output logic [7:0] rx_char,
   output logic rx_frame_err,
   output logic rx_parity_err,
   output logic rx_break,
   output logic rx_shift_overrun,
   // Transmit handshake
   output logic tx_take,
   output logic tx_shift_busy,
   input wire logic [7:0] tx_char,
   input wire logic tx_char_valid
);
   // Quiet at time zero; the character lines carry junk outside a pulse
   initial begin
      rx_char_valid = 1'b0;
      rx_char = 8'hA5;
      {rx_frame_err, rx_parity_err, rx_shift_overrun, rx_break} = 4'h0;
      tx_take = 1'b0;
      tx_shift_busy = 1'b0;
   end

   // One received frame; e is {framing, parity, overrun, break}
   task automatic send(input logic [7:0] c, input logic [3:0] e);
      @(posedge clock);
      rx_char_valid <= !e[1]; // An overrun alone delivers no character
      rx_char <= c; // Break comes as a framing fault with all-zero data
      {rx_frame_err, rx_parity_err, rx_shift_overrun, rx_break} <= e;
      @(posedge clock);
      rx_char_valid <= 1'b0;
      rx_char <= ~c; // Released lines must not keep showing the character
      {rx_frame_err, rx_parity_err, rx_shift_overrun, rx_break} <= 4'h0;
   endtask

   // Ask for the next character; the answer stands one cycle after the take
   task automatic take(output logic got, output logic [7:0] c);
      @(posedge clock);
      tx_take <= 1'b1;
      @(posedge clock);
      tx_take <= 1'b0;
      #1;
      got = tx_char_valid;
      c = tx_char;
   endtask

   // Shifter occupancy level
   task automatic set_busy(input logic b);
      @(posedge clock);
      tx_shift_busy <= b;
   endtask
endmodule
`default_nettype wire

// *** bench/uds_bench.sv ***
// Self-checking bench for the data and status register block.
// Assumes the engine model stands on the line side and APB-like access.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module uart_data_status_regs_bench;
   import uds_pkg::*;
   localparam int D = UDS_FIFO_DEPTH;
   // Bench-driven inputs
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   // Design outputs and engine lines
   logic [31:0] prdata, line_setup, baud_divider, queue_inspect;
   logic pready, pslverr, rx_char_valid, rx_frame_err, rx_parity_err, rx_break;
   logic rx_shift_overrun, tx_take, tx_shift_busy, tx_char_valid, tx_pending;
   logic [7:0] rx_char, tx_char;
   int error_cnt = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic er;

   // 100 MHz clock
   always #5 clock = ~clock;

   uds_regs #(.DEPTH(D)) DUT (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err), .rx_break(rx_break),
      .rx_shift_overrun(rx_shift_overrun), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
      .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_pending(tx_pending),
      .line_setup(line_setup), .baud_divider(baud_divider), .queue_inspect(queue_inspect));

   uds_engine_model ENG (.clock(clock), .rst_b(rst_b), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err),
      .rx_break(rx_break), .rx_shift_overrun(rx_shift_overrun), .tx_take(tx_take),
      .tx_shift_busy(tx_shift_busy), .tx_char(tx_char), .tx_char_valid(tx_char_valid));

   // Expected status word; fl is {framing, parity, overrun, break}
   function automatic logic [31:0] st(int rc, int tc, logic [3:0] fl, logic idle);
      logic [31:0] s;
      s = 32'h0000_0000;
      s[31:26] = 6'(rc);
      s[25:20] = 6'(tc);
      s[10] = (rc == D);
      s[9] = (tc == D);
      s[8] = (rc >= D / 2);
      s[7] = (tc < D / 2);
      s[6:3] = fl;
      s[2] = (tc == 0);
      s[1] = idle;
      s[0] = (rc > 0);
      return s;
   endfunction

   // One transfer; the answer is taken at the edge where pready is high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      #1;
      for (i = 0; i < 8 && pready !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      if (pready !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: pready never came", $time);
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask

   task automatic t_reset;
      apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
      `CHK(rd, st(0, 0, 4'h0, 1'b1))
      apb(1'b0, UDS_OFF_CHAR_PORT, 32'h0);
      `CHK(rd, UDS_RST_CHAR_PORT)
      `CHK(er, 1'b0)
      `CHK(tx_pending, 1'b0)
      $display("t_reset done");
   endtask

   // Plain storage words, their port copies, and two unmapped addresses
   task automatic t_regs;
      logic [11:0] offs [3] = '{UDS_OFF_LINE_SETUP, UDS_OFF_BAUD_DIVIDER, UDS_OFF_QUEUE_INSPECT};
      int k;
      for (k = 0; k < 3; k++) begin
         apb(1'b0, offs[k], 32'h0);
         `CHK(rd, 32'h0000_0000)
         apb(1'b1, offs[k], 32'hA5C3_0F10 + k);
         apb(1'b0, offs[k], 32'h0);
         `CHK(rd, 32'hA5C3_0F10 + k)
         `CHK(er, 1'b0)
      end
      `CHK({line_setup, baud_divider, queue_inspect}, {32'hA5C3_0F10, 32'hA5C3_0F11, 32'hA5C3_0F12})
      apb(1'b1, 12'h014, 32'hFFFF_FFFF);
      apb(1'b0, 12'h014, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      apb(1'b0, 12'h002, 32'h0);
      `CHK(er, 1'b1)
      $display("t_regs done");
   endtask

   // Fill the transmit queue past full, then drain it through the engine
   task automatic t_tx;
      int k;
      logic got;
      logic [7:0] c;
      for (k = 0; k <= D; k++) begin
         apb(1'b1, UDS_OFF_CHAR_PORT, {24'hFFFFFF, 8'(8'h30 + k)});
         apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
         `CHK(rd, st(0, (k < D) ? k + 1 : D, 4'h0, 1'b1))
      end
      `CHK(tx_pending, 1'b1)
      for (k = 0; k <= D; k++) begin
         ENG.take(got, c);
         `CHK(got, (k < D))
         if (k < D) `CHK(c, 8'(8'h30 + k))
      end
      `CHK(tx_pending, 1'b0)
      ENG.set_busy(1'b1);
      apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
      `CHK(rd, st(0, 0, 4'h0, 1'b0))
      ENG.set_busy(1'b0);
      $display("t_tx done");
   endtask

   // Fill the receive queue past full, read it back, then read it empty
   task automatic t_rx;
      int k;
      for (k = 0; k <= D; k++) begin
         ENG.send(8'(8'hC0 + k), 4'h0);
         apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
         `CHK(rd, st((k < D) ? k + 1 : D, 0, (k < D) ? 4'h0 : 4'h2, 1'b1))
      end
      for (k = 0; k <= D; k++) begin
         apb(1'b0, UDS_OFF_CHAR_PORT, 32'h0);
         `CHK(rd, (k < D) ? 32'(8'hC0 + k) : 32'h0)
         apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
         `CHK(rd, st((k < D) ? D - 1 - k : 0, 0, 4'h2, 1'b1))
      end
      // Mid-run reset must drop the queued byte, the lost flag and the setup words
      ENG.send(8'h5A, 4'h0);
      @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      rst_b <= 1'b1;
      apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
      `CHK(rd, st(0, 0, 4'h0, 1'b1))
      `CHK({line_setup, baud_divider, queue_inspect}, 96'h0)
      apb(1'b1, UDS_OFF_LINE_STATE, 32'h0);
      $display("t_rx done");
   endtask

   // Every fault kind: flags pile up, nothing is queued, clears are selective
   task automatic t_err;
      logic [3:0] codes [4] = '{4'h8, 4'h4, 4'h9, 4'h2};
      logic [3:0] acc;
      int k;
      acc = 4'h0;
      for (k = 0; k < 4; k++) begin
         ENG.send((k == 2) ? 8'h00 : 8'h77, codes[k]);
         acc = acc | codes[k];
         apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
         `CHK(rd, st(0, 0, acc, 1'b1))
      end
      apb(1'b1, UDS_OFF_LINE_STATE, 32'hFFFF_FFBF);
      apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
      `CHK(rd, st(0, 0, 4'h7, 1'b1))
      apb(1'b1, UDS_OFF_LINE_STATE, 32'h0);
      apb(1'b0, UDS_OFF_LINE_STATE, 32'h0);
      `CHK(rd, st(0, 0, 4'h0, 1'b1))
      $display("t_err done");
   endtask

   // Verdict and end of run
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Main sequence after a three-cycle reset
   initial begin
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      t_reset();
      t_regs();
      t_tx();
      t_rx();
      t_err();
      stop_test();
   end
endmodule
`default_nettype wire
